// >>> hw/i2cbc_defines.vh
// constants for the i2c master collision and baud reload block
// Functional notes
// R01: driving a one on sda but reading zero flags a collision and idles the port.
// R02: collision in a transfer stops it, clears buffer full, releases lines, buffer writable.
// R03: collision in start/restart/stop/ack aborts it, releases lines, clears its request bit.
// R04: after collision keep watching lines; a seen stop sets the serial irq flag.
// R05: a new buffer write after collision sends from the first data bit.
// R06: software takes the bus only when stop seen, or start and stop both clear.
// R07: sda or scl low when a start begins aborts start and flags collision.
// R08: in start, sda high loads counter; scl low while sda high is a collision.
// R09: sda low during first start count resets counter and drives sda low at once.
// R10: after sda low in start, count again ignoring scl, then drive scl low.
// R11: restart releases sda, counts, releases scl, samples sda once scl high.
// R12: in restart sda falling early is fine; scl falling before sda driven is collision.
// R13: both high at timeout: drive sda low, count, drive scl low regardless.
// R14: stop holds sda low, releases scl, counts after scl high, releases sda, checks sda.
// R15: scl low during stop before sda released is a collision.
// R16: counter reloads from reload value register and starts on a buffer write.
// R17: when an operation completes the counter stops and the clock pin holds.
// R18: two reloads per bus clock period, bus clock is fosc over 8(reload+1).
// R19: software must not use reload values 0x00, 0x01 or 0x02 for i2c.
// R20: counter decrements once per instruction cycle, a quarter of the oscillator rate.
`ifndef I2CBC_DEFINES_VH
`define I2CBC_DEFINES_VH
`define I2CBC_TICK_DIV      2'h3
`define I2CBC_RELOAD_RESET  8'h13
`define I2CBC_ST_IDLE       4'h0
`define I2CBC_ST_S_CHK      4'h1
`define I2CBC_ST_S_CNT1     4'h2
`define I2CBC_ST_S_CNT2     4'h3
`define I2CBC_ST_R_CNT1     4'h4
`define I2CBC_ST_R_SCLH     4'h5
`define I2CBC_ST_R_CNT2     4'h6
`define I2CBC_ST_R_CNT3     4'h7
`define I2CBC_ST_P_SDAL     4'h8
`define I2CBC_ST_P_SCLH     4'h9
`define I2CBC_ST_P_CNT      4'ha
`define I2CBC_ST_P_CHK      4'hb
`define I2CBC_ST_TX_LOW     4'hc
`define I2CBC_ST_TX_HIGH    4'hd
`define I2CBC_ST_A_LOW      4'he
`define I2CBC_ST_A_HIGH     4'hf
`endif

// >>> hw/i2cbc_master.v
// i2c master collision detection, recovery and baud reload counter
`timescale 1ns/1ns
`default_nettype none
`include "i2cbc_defines.vh"
module i2cbc_master #(
   parameter DW = 8
) (
   input  wire          mclk,
   input  wire          reset_n,
   input  wire          clk_en,
   input  wire          sda_in,
   input  wire          scl_in,
   output reg           sda_out,
   output reg           sda_oe_n,
   output reg           scl_out,
   output reg           scl_oe_n,
   input  wire [DW-1:0] reload_value_reg,
   input  wire [DW-1:0] buf_wdata,
   input  wire          buf_wr,
   input  wire          start_req,
   input  wire          restart_req,
   input  wire          stop_req,
   input  wire          ack_req,
   input  wire          ack_data,
   input  wire          coll_clr,
   input  wire          irq_clr,
   output reg           buffer_full_flag,
   output reg           collision_flag,
   output reg           serial_irq_flag,
   output reg  [3:0]    sequence_control_reg,
   output reg           start_seen,
   output reg           stop_seen,
   output reg           busy
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: first stage read only by the second
   reg [1:0] sda_s_q;
   reg [1:0] scl_s_q;
   reg       sda_p_q;
   reg       scl_p_q;
   wire      sda_h = sda_s_q[1];
   wire      scl_h = scl_s_q[1];
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sda_s_q <= 2'h3;
         scl_s_q <= 2'h3;
         sda_p_q <= 1'b1;
         scl_p_q <= 1'b1;
      end else if (clk_en) begin
         sda_s_q <= {sda_s_q[0], sda_in};
         scl_s_q <= {scl_s_q[0], scl_in};
         sda_p_q <= sda_h;
         scl_p_q <= scl_h;
      end
   end

   // bus start and stop watch, active even after a collision
   wire bus_start = scl_h && scl_p_q && sda_p_q && !sda_h;
   wire bus_stop  = scl_h && scl_p_q && !sda_p_q && sda_h;

   ////////////////////////////////////////////////////////////////////////////
   // instruction-cycle tick: counter steps at a quarter of mclk
   reg [1:0] pre_q;
   wire      tick = (pre_q == `I2CBC_TICK_DIV); // [R20]
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         pre_q <= 2'h0;
      else if (clk_en)
         pre_q <= pre_q + 2'h1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer and baud reload counter
   reg [3:0]    st_q;
   reg [DW-1:0] brg_q;
   reg          brg_run_q;
   reg [DW-1:0] sh_q;
   reg [3:0]    bit_q;
   wire         brg_done = brg_run_q && tick && (brg_q == {DW{1'b0}});
   // sda we actually release (want high) vs sample
   wire         sda_rel = sda_oe_n;

   task do_idle;
      begin
         st_q      <= `I2CBC_ST_IDLE;
         brg_run_q <= 1'b0;
         sequence_control_reg <= 4'h0;
         busy      <= 1'b0;
      end
   endtask

   task collide;
      begin
         collision_flag   <= 1'b1;
         buffer_full_flag <= 1'b0; // [R02]
         sda_oe_n         <= 1'b1; // [R02] [R03]
         scl_oe_n         <= 1'b1;
         bit_q            <= 4'h0; // [R05]
         do_idle;                  // [R03]
      end
   endtask

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= `I2CBC_ST_IDLE;
         brg_q <= {DW{1'b0}};
         brg_run_q <= 1'b0;
         sh_q <= {DW{1'b0}};
         bit_q <= 4'h0;
         sda_out <= 1'b0;
         scl_out <= 1'b0;
         sda_oe_n <= 1'b1;
         scl_oe_n <= 1'b1;
         buffer_full_flag <= 1'b0;
         collision_flag <= 1'b0;
         serial_irq_flag <= 1'b0;
         sequence_control_reg <= 4'h0;
         start_seen <= 1'b0;
         stop_seen <= 1'b0;
         busy <= 1'b0;
      end else if (clk_en) begin
         // set wins over software clear
         if (coll_clr)
            collision_flag <= 1'b0;
         if (irq_clr)
            serial_irq_flag <= 1'b0;
         if (bus_start) begin
            start_seen <= 1'b1;
            stop_seen  <= 1'b0;
         end
         if (bus_stop) begin
            stop_seen  <= 1'b1; // [R06]
            start_seen <= 1'b0;
            serial_irq_flag <= 1'b1; // [R04]
         end
         // counter: reload on zero, hold when stopped [R17]
         if (brg_run_q && tick)
            brg_q <= (brg_q == {DW{1'b0}}) ? reload_value_reg : brg_q - 1'b1; // [R16] [R18]
         case (st_q)
            `I2CBC_ST_IDLE: begin
               if (start_req) begin
                  sequence_control_reg <= 4'h1;
                  busy <= 1'b1;
                  st_q <= `I2CBC_ST_S_CHK;
               end else if (restart_req) begin
                  sequence_control_reg <= 4'h2;
                  busy <= 1'b1;
                  sda_oe_n <= 1'b1; // [R11]
                  brg_q <= reload_value_reg;
                  brg_run_q <= 1'b1;
                  st_q <= `I2CBC_ST_R_CNT1;
               end else if (stop_req) begin
                  sequence_control_reg <= 4'h4;
                  busy <= 1'b1;
                  sda_oe_n <= 1'b0; // [R14]
                  st_q <= `I2CBC_ST_P_SDAL;
               end else if (ack_req) begin
                  sequence_control_reg <= 4'h8;
                  busy <= 1'b1;
                  scl_oe_n <= 1'b0;
                  sda_oe_n <= ack_data;
                  brg_q <= reload_value_reg;
                  brg_run_q <= 1'b1;
                  st_q <= `I2CBC_ST_A_LOW;
               end else if (buf_wr) begin
                  sh_q <= buf_wdata;
                  bit_q <= 4'h0; // [R05]
                  buffer_full_flag <= 1'b1;
                  busy <= 1'b1;
                  scl_oe_n <= 1'b0;
                  sda_oe_n <= buf_wdata[DW-1];
                  brg_q <= reload_value_reg; // [R16]
                  brg_run_q <= 1'b1;
                  st_q <= `I2CBC_ST_TX_LOW;
               end
            end
            `I2CBC_ST_S_CHK: begin
               if (!sda_h || !scl_h)
                  collide; // [R07]
               else begin
                  brg_q <= reload_value_reg; // [R08]
                  brg_run_q <= 1'b1;
                  st_q <= `I2CBC_ST_S_CNT1;
               end
            end
            `I2CBC_ST_S_CNT1: begin
               if (!scl_h && sda_h)
                  collide; // [R08]
               else if (!sda_h || brg_done) begin
                  sda_oe_n <= 1'b0; // [R09]
                  brg_q <= reload_value_reg; // [R09] [R10]
                  st_q <= `I2CBC_ST_S_CNT2;
               end
            end
            `I2CBC_ST_S_CNT2: begin
               // scl low here is another master's start, not a collision
               if (brg_done) begin
                  scl_oe_n <= 1'b0; // [R10]
                  serial_irq_flag <= 1'b1;
                  do_idle;
               end
            end
            `I2CBC_ST_R_CNT1: begin
               if (brg_done) begin
                  scl_oe_n <= 1'b1; // [R11]
                  brg_run_q <= 1'b0;
                  st_q <= `I2CBC_ST_R_SCLH;
               end
            end
            `I2CBC_ST_R_SCLH: begin
               if (scl_h) begin
                  if (!sda_h)
                     collide; // [R11]
                  else begin
                     brg_q <= reload_value_reg; // [R12]
                     brg_run_q <= 1'b1;
                     st_q <= `I2CBC_ST_R_CNT2;
                  end
               end
            end
            `I2CBC_ST_R_CNT2: begin
               if (!scl_h && sda_rel && sda_h)
                  collide; // [R12]
               else if (brg_done) begin
                  sda_oe_n <= 1'b0; // [R13]
                  brg_q <= reload_value_reg;
                  st_q <= `I2CBC_ST_R_CNT3;
               end
            end
            `I2CBC_ST_R_CNT3: begin
               if (brg_done) begin
                  scl_oe_n <= 1'b0; // [R13]
                  serial_irq_flag <= 1'b1;
                  do_idle;
               end
            end
            `I2CBC_ST_P_SDAL: begin
               if (!sda_h) begin
                  scl_oe_n <= 1'b1; // [R14]
                  st_q <= `I2CBC_ST_P_SCLH;
               end
            end
            `I2CBC_ST_P_SCLH: begin
               if (scl_h) begin
                  brg_q <= reload_value_reg; // [R14]
                  brg_run_q <= 1'b1;
                  st_q <= `I2CBC_ST_P_CNT;
               end
            end
            `I2CBC_ST_P_CNT: begin
               if (!scl_h)
                  collide; // [R15]
               else if (brg_done) begin
                  sda_oe_n <= 1'b1; // [R14]
                  brg_q <= reload_value_reg;
                  st_q <= `I2CBC_ST_P_CHK;
               end
            end
            `I2CBC_ST_P_CHK: begin
               if (brg_done) begin
                  if (!sda_h)
                     collide; // [R14]
                  else begin
                     serial_irq_flag <= 1'b1;
                     do_idle;
                  end
               end
            end
            `I2CBC_ST_TX_LOW: begin
               if (brg_done) begin
                  scl_oe_n <= 1'b1;
                  brg_run_q <= 1'b0;
                  st_q <= `I2CBC_ST_TX_HIGH;
               end
            end
            `I2CBC_ST_TX_HIGH: begin
               // counting waits for scl to really rise (clock stretch)
               if (scl_h && !brg_run_q) begin
                  brg_q <= reload_value_reg;
                  brg_run_q <= 1'b1;
               end
               if (scl_h && sda_rel && !sda_h && bit_q != 4'h8)
                  collide; // [R01]
               else if (brg_done) begin
                  scl_oe_n <= 1'b0;
                  brg_q <= reload_value_reg;
                  if (bit_q == 4'h8) begin
                     // ninth clock was the ack slot
                     buffer_full_flag <= 1'b0;
                     serial_irq_flag <= 1'b1;
                     sda_oe_n <= 1'b1;
                     bit_q <= 4'h0;
                     do_idle; // [R17]
                  end else begin
                     bit_q <= bit_q + 4'h1;
                     sh_q <= {sh_q[DW-2:0], 1'b0};
                     sda_oe_n <= (bit_q == 4'h7) ? 1'b1 : sh_q[DW-2];
                     st_q <= `I2CBC_ST_TX_LOW;
                  end
               end
            end
            `I2CBC_ST_A_LOW: begin
               if (brg_done) begin
                  scl_oe_n <= 1'b1;
                  brg_run_q <= 1'b0;
                  st_q <= `I2CBC_ST_A_HIGH;
               end
            end
            `I2CBC_ST_A_HIGH: begin
               if (scl_h && !brg_run_q) begin
                  brg_q <= reload_value_reg;
                  brg_run_q <= 1'b1;
               end
               if (scl_h && sda_rel && !sda_h)
                  collide; // [R03]
               else if (brg_done) begin
                  scl_oe_n <= 1'b0;
                  serial_irq_flag <= 1'b1;
                  do_idle;
               end
            end
            default: do_idle;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> dv/i2cbc_bus_model.sv
// far side of the bus: pull-ups and a second master that can pull either line low
`timescale 1ns/1ns
`default_nettype none
module i2cbc_bus_model (
   input  wire logic sda_oe_n,
   input  wire logic scl_oe_n,
   input  wire logic hold_sda,
   input  wire logic hold_scl,
   output wire logic sda,
   output wire logic scl
);
   // wired-and with pull-up, so a released line reads high, never stale
   assign sda = sda_oe_n & ~hold_sda;
   assign scl = scl_oe_n & ~hold_scl;
endmodule
`default_nettype wire

// >>> dv/i2cbc_chk.sv
// port assertions for the collision and reload block
`timescale 1ns/1ns
`default_nettype none
module i2cbc_chk (
   input wire logic       mclk,
   input wire logic       reset_n,
   input wire logic       start_req,
   input wire logic       busy,
   input wire logic       sda_in,
   input wire logic       scl_in,
   input wire logic       sda_oe_n,
   input wire logic       scl_oe_n,
   input wire logic       buffer_full_flag,
   input wire logic       collision_flag,
   input wire logic       serial_irq_flag,
   input wire logic [3:0] sequence_control_reg
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   ////////////////////
   sequence s_coll; $rose(collision_flag); endsequence
   sequence s_freed; sda_oe_n && scl_oe_n && sequence_control_reg == 4'h0; endsequence
   // lines are synced on the way in, so allow a few cycles of lag
   sequence s_blocked; start_req && !busy && !scl_in ##1 !scl_in [*4]; endsequence
   sequence s_bus_stop; scl_in && !sda_in ##1 scl_in && sda_in; endsequence
   property p_coll_free; s_coll |-> ##[0:2] s_freed; endproperty
   property p_coll_bf; s_coll |-> ##[0:2] !buffer_full_flag; endproperty
   property p_coll_idle; s_coll |-> ##[0:3] !busy; endproperty
   property p_blocked; s_blocked |-> ##[0:6] collision_flag && sda_oe_n; endproperty
   property p_stop_irq; s_bus_stop |-> ##[1:6] serial_irq_flag; endproperty
   property p_scl_after_sda;
      $fell(scl_oe_n) && $past(sequence_control_reg[0]) |-> !$past(sda_oe_n, 8);
   endproperty
   property p_rs_drive; $fell(sda_oe_n) && $past(sequence_control_reg[1]) |-> scl_oe_n;
   endproperty
   property p_idle_hold;
      !busy && !$past(busy) |-> $stable(sda_oe_n) && $stable(scl_oe_n);
   endproperty
   a_coll_free: assert property (p_coll_free) else $error("lines held after collision");
   a_coll_bf: assert property (p_coll_bf) else $error("buffer full kept");
   a_coll_idle: assert property (p_coll_idle) else $error("busy after collision");
   a_blocked: assert property (p_blocked) else $error("start on low line");
   a_stop_irq: assert property (p_stop_irq) else $error("bus stop missed");
   a_scl_after_sda: assert property (p_scl_after_sda) else $error("scl early");
   a_rs_drive: assert property (p_rs_drive) else $error("restart sda with scl low");
   a_idle_hold: assert property (p_idle_hold) else $error("pins moved in idle");
endmodule
bind i2cbc_master i2cbc_chk i_chk (.mclk, .reset_n, .start_req, .busy, .sda_in, .scl_in,
   .sda_oe_n, .scl_oe_n, .buffer_full_flag, .collision_flag, .serial_irq_flag,
   .sequence_control_reg);
`default_nettype wire

// >>> dv/i2cbc_tb.sv
// self-checking bench for the collision and reload block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH %0t %h %h", $time, g, e); end end
module testbench;
   // lowest reload that is legal for i2c keeps the run short
   localparam logic [7:0] RL = 8'h03;
   localparam int         T  = 4 * (RL + 1);
   logic       mclk, reset_n, hold_sda, hold_scl, buf_wr, coll_clr, irq_clr;
   logic       start_req, restart_req, stop_req, ack_req, ack_data, clk_en;
   logic [7:0] buf_wdata;
   wire logic  sda_in, scl_in, sda_oe_n, scl_oe_n, bf, coll, irq, ps, busy, so, co, ss;
   wire logic [3:0] seq;
   wire logic [7:0] st = {sda_oe_n, scl_oe_n, coll, busy, seq};
   int         bad_count = 0, n_compared = 0, cyc = 0;
   i2cbc_bus_model i_bus (.sda_oe_n, .scl_oe_n, .hold_sda, .hold_scl, .sda(sda_in),
      .scl(scl_in));
   i2cbc_master i_dut (.mclk, .reset_n, .clk_en, .sda_in, .scl_in, .sda_out(so),
      .sda_oe_n, .scl_out(co), .scl_oe_n, .reload_value_reg(RL), .buf_wdata, .buf_wr,
      .start_req, .restart_req, .stop_req, .ack_req, .ack_data, .coll_clr,
      .irq_clr, .buffer_full_flag(bf), .collision_flag(coll), .serial_irq_flag(irq),
      .sequence_control_reg(seq), .start_seen(ss), .stop_seen(ps), .busy);
   ////////////////////
   initial begin
      mclk = 0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         give_verdict();
      end
   end
   task automatic give_verdict;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wait_on(input int k, input logic v);
      int n;
      n = 0;
      while ((k ? scl_oe_n : busy) !== v && n < 2000) begin
         @(negedge mclk);
         n++;
      end
   endtask
   task automatic run(input int k);
      @(negedge mclk);
      case (k)
         0: start_req = 1;
         1: restart_req = 1;
         2: stop_req = 1;
         3: buf_wr = 1;
         default: ack_req = 1;
      endcase
      @(negedge mclk);
      {start_req, restart_req, stop_req, buf_wr, ack_req} = 5'h0;
      @(negedge mclk);
      wait_on(0, 1'b0);
   endtask
   task automatic clr;
      {coll_clr, irq_clr} = 2'h3;
      @(negedge mclk);
      {coll_clr, irq_clr} = 2'h0;
   endtask
   ////////////////////
   task automatic t_start;
      clr();
      hold_scl = 1;
      run(0);
      `CHK(st, 8'he0)
      // keep the line low long enough for the blocked-start assertion to engage
      repeat (4) @(negedge mclk);
      hold_scl = 0;
      clr();
      run(0);
      `CHK({st, irq}, 9'h001)
      `CHK(ss, 1'b1)
      `CHK({so, co}, 2'h0)
      // a one on bit 6 meets a held-low line
      hold_sda = 1;
      buf_wdata = 8'h7f;
      run(3);
      `CHK(st, 8'he0)
      `CHK(bf, 1'b0)
      hold_sda = 0;
      repeat (8) @(negedge mclk);
      `CHK({irq, ps}, 2'h3)
      $display("start and transmit collision done");
   endtask
   task automatic t_fresh;
      int n;
      clr();
      run(0);
      buf_wdata = 8'h80;
      run(3);
      @(negedge mclk);
      buf_wr = 1;
      @(negedge mclk);
      buf_wr = 0;
      wait_on(1, 1'b1);
      `CHK(sda_oe_n, 1'b1)
      n = 0;
      while (scl_oe_n === 1'b1 && n < 1000) begin
         @(negedge mclk);
         n++;
      end
      `CHK(n >= T && n <= T + 4, 1'b1)
      wait_on(1, 1'b1);
      `CHK(sda_oe_n, 1'b0)
      wait_on(0, 1'b0);
      `CHK(scl_oe_n, 1'b0)
      hold_sda = 1;
      run(2);
      `CHK(st, 8'he0)
      hold_sda = 0;
      $display("fresh byte and stop collision done");
   endtask
   task automatic t_seq;
      // a frozen block must not take a start request
      clk_en = 0;
      start_req = 1;
      repeat (3) @(negedge mclk);
      start_req = 0;
      clk_en = 1;
      @(negedge mclk);
      `CHK({busy, seq}, 5'h00)
      clr();
      run(0);
      run(2);
      `CHK({st, irq, ps}, 10'h303)
      clr();
      run(0);
      run(1);
      `CHK({st, irq}, 9'h001)
      hold_sda = 1;
      run(1);
      `CHK(st, 8'he0)
      // released ack bit meets a held-low line
      clr();
      ack_data = 1;
      run(4);
      `CHK(st, 8'he0)
      hold_sda = 0;
      $display("stop and restart done");
   endtask
   initial begin
      {reset_n, hold_sda, hold_scl, buf_wr, coll_clr, irq_clr} = 6'h0;
      {start_req, restart_req, stop_req, ack_req, ack_data} = 5'h0;
      clk_en = 1;
      buf_wdata = 8'h00;
      repeat (2) @(negedge mclk);
      reset_n = 1;
      t_start();
      t_fresh();
      t_seq();
      give_verdict();
   end
endmodule
`default_nettype wire
